//--- design/sptx_pkg.sv
// sptx_pkg: constants and types for the serial audio input stage
// assumes: included before the input stage module
package sptx_pkg;
	localparam int SAMPLE_W = 24;
	localparam logic [4:0] BIT_CNT_MAX = 5'h1f;
	// oversampling ratios per frame and biphase bits per frame
	localparam int RATIO_384 = 384;
	localparam int RATIO_256 = 256;
	localparam int BIPHASE_PER_FRAME = 128;
	localparam logic [1:0] DIV_384 = 2'(RATIO_384 / BIPHASE_PER_FRAME - 1);
	localparam logic [1:0] DIV_256 = 2'(RATIO_256 / BIPHASE_PER_FRAME - 1);
	localparam logic [1:0] DIV_ZERO = 2'h0;
	localparam logic [4:0] CNT_ZERO = 5'h00;
	localparam logic [4:0] CNT_ONE = 5'h01;
	typedef enum logic {
		SPTX_FMT_I2S = 1'b0,
		SPTX_FMT_LJ = 1'b1
	} sptx_fmt_t;
endpackage

//--- design/sptx_serial_in.sv
// sptx_serial_in: serial audio receiver and biphase clock divider
// assumes: bit clock, frame sync, data and oversampling clock synchronous to ref_clk
// Behaviour
// - i2s: sync low left, high right
// - i2s: msb one bit after transition
// - sample data and sync on rising edge
// - left-justified: sync high left, low right
// - left-justified: msb at sync transition
// - biphase enable divided from oversampling clock
// - divider supports 384 and 256 ratios
`timescale 1ns/1ns
module sptx_serial_in
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire sptx_pkg::sptx_fmt_t fmt_sel,
	input wire logic ratio_256_sel,
	input wire logic bit_clk,
	input wire logic frame_sync,
	input wire logic ser_data,
	input wire logic oversampling_clock_in,
	output logic [sptx_pkg::SAMPLE_W-1:0] left_sample,
	output logic [sptx_pkg::SAMPLE_W-1:0] right_sample,
	output logic pair_valid,
	output logic biphase_en
);
	import sptx_pkg::*;

	// ----------------------------------------
	// input edge detection
	// ----------------------------------------
	logic bclk_q, bclk_d, osc_q, osc_d;
	logic rise, osc_rise;
	always_comb begin
		bclk_d = bit_clk;
		osc_d = oversampling_clock_in;
		rise = bit_clk & ~bclk_q;
		osc_rise = oversampling_clock_in & ~osc_q;
	end
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bclk_q <= 1'b0;
			osc_q <= 1'b0;
		end else begin
			bclk_q <= bclk_d;
			osc_q <= osc_d;
		end
	end

	// ----------------------------------------
	// serial capture and pairing
	// ----------------------------------------
	logic fs_q, fs_d;
	logic [SAMPLE_W-1:0] sh_q, sh_d, lh_q, lh_d, lo_q, lo_d, ro_q, ro_d;
	logic [4:0] cnt_q, cnt_d;
	logic pv_q, pv_d;
	logic fs_edge, in_left;
	always_comb begin
		fs_d = fs_q;
		sh_d = sh_q;
		lh_d = lh_q;
		lo_d = lo_q;
		ro_d = ro_q;
		cnt_d = cnt_q;
		pv_d = 1'b0;
		fs_edge = frame_sync != fs_q;
		// channel of the word now ending, by the previous sync level
		in_left = (fmt_sel == SPTX_FMT_I2S) ? ~fs_q : fs_q;
		if (rise) begin
			fs_d = frame_sync;
			if (fs_edge) begin
				// close the finished word
				if (in_left)
					lh_d = sh_q;
				else begin
					lo_d = lh_q;
					ro_d = sh_q;
					pv_d = 1'b1;
				end
				if (fmt_sel == SPTX_FMT_I2S) begin
					// bit at the transition still belongs to the old word
					if (cnt_q < 5'(SAMPLE_W)) begin
						if (in_left)
							lh_d = {sh_q[SAMPLE_W-2:0], ser_data};
						else
							ro_d = {sh_q[SAMPLE_W-2:0], ser_data};
					end
					// new word starts empty, its msb comes with the next rise
					sh_d = '0;
					cnt_d = CNT_ZERO;
				end else begin
					sh_d = {{(SAMPLE_W-1){1'b0}}, ser_data};
					cnt_d = CNT_ONE;
				end
			end else if (cnt_q < 5'(SAMPLE_W)) begin
				sh_d = {sh_q[SAMPLE_W-2:0], ser_data};
				cnt_d = cnt_q + CNT_ONE;
			end
		end
	end
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fs_q <= 1'b0;
			sh_q <= '0;
			lh_q <= '0;
			lo_q <= '0;
			ro_q <= '0;
			cnt_q <= CNT_ZERO;
			pv_q <= 1'b0;
		end else begin
			fs_q <= fs_d;
			sh_q <= sh_d;
			lh_q <= lh_d;
			lo_q <= lo_d;
			ro_q <= ro_d;
			cnt_q <= cnt_d;
			pv_q <= pv_d;
		end
	end
	assign left_sample = lo_q;
	assign right_sample = ro_q;
	assign pair_valid = pv_q;

	// ----------------------------------------
	// biphase clock divider
	// ----------------------------------------
	logic [1:0] div_q, div_d;
	logic bp_q, bp_d;
	logic [1:0] div_end;
	always_comb begin
		div_end = ratio_256_sel ? DIV_256 : DIV_384;
		div_d = div_q;
		bp_d = 1'b0;
		if (osc_rise) begin
			if (div_q >= div_end) begin
				div_d = DIV_ZERO;
				bp_d = 1'b1;
			end else
				div_d = div_q + 2'h1;
		end
	end
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_q <= DIV_ZERO;
			bp_q <= 1'b0;
		end else begin
			div_q <= div_d;
			bp_q <= bp_d;
		end
	end
	assign biphase_en = bp_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_pair_on_close: assert property (@(posedge ref_clk) disable iff (sys_rst)
		pair_valid |-> $past(rise) && $past(fs_edge) && !$past(in_left))
		else $error("pair without closing edge");
	a_pair_once: assert property (@(posedge ref_clk) disable iff (sys_rst)
		pair_valid |=> !pair_valid)
		else $error("pair valid longer than one cycle");
	a_lj_first_bit: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise && fs_edge && fmt_sel == SPTX_FMT_LJ |=> cnt_q == CNT_ONE)
		else $error("lj msb not taken at transition");
	a_i2s_delay: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise && fs_edge && fmt_sel == SPTX_FMT_I2S |=> cnt_q == CNT_ZERO)
		else $error("i2s transition bit not skipped");
	a_hold_no_edge: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!rise |=> $stable(cnt_q) && $stable(sh_q))
		else $error("capture without rising edge");
	a_div_256: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ratio_256_sel && biphase_en |=> div_q == DIV_ZERO)
		else $error("divider not restarted");
	a_div_bound: assert property (@(posedge ref_clk) disable iff (sys_rst)
		div_q <= DIV_384)
		else $error("divider overrun");
	a_bp_cause: assert property (@(posedge ref_clk) disable iff (sys_rst)
		biphase_en |-> $past(osc_rise))
		else $error("biphase pulse without oscillator edge");

	// channel is judged by the sync level that the closing edge leaves
	a_i2s_pair_fall: assert property (@(posedge ref_clk) disable iff (sys_rst)
		pair_valid && $past(fmt_sel) == SPTX_FMT_I2S |-> !$past(frame_sync))
		else $error("i2s pair closed without sync fall");
	a_lj_pair_rise: assert property (@(posedge ref_clk) disable iff (sys_rst)
		pair_valid && $past(fmt_sel) == SPTX_FMT_LJ |-> $past(frame_sync))
		else $error("lj pair closed without sync rise");

	// the bit at an i2s transition ends the old word
	a_i2s_old_left: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise && fs_edge && fmt_sel == SPTX_FMT_I2S && in_left && cnt_q < 5'(SAMPLE_W)
		|=> lh_q[0] == $past(ser_data))
		else $error("i2s transition bit lost from left word");
	a_i2s_old_right: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise && fs_edge && fmt_sel == SPTX_FMT_I2S && !in_left && cnt_q < 5'(SAMPLE_W)
		|=> right_sample[0] == $past(ser_data))
		else $error("i2s transition bit lost from right word");

	// the bit at a left-justified transition opens the new word
	a_lj_msb_taken: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise && fs_edge && fmt_sel == SPTX_FMT_LJ |=> sh_q[0] == $past(ser_data))
		else $error("lj transition bit not shifted in");

	// sync and word length follow the rising bit clock only
	a_sync_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise |=> fs_q == $past(frame_sync))
		else $error("sync level not taken on rising edge");
	a_cnt_bound: assert property (@(posedge ref_clk) disable iff (sys_rst)
		cnt_q <= 5'(SAMPLE_W))
		else $error("word counter beyond sample width");

	// divider wraps on the last oscillator rise of each ratio
	a_div_wrap_384: assert property (@(posedge ref_clk) disable iff (sys_rst)
		osc_rise && !ratio_256_sel && div_q == DIV_384 |=> biphase_en)
		else $error("no biphase pulse at 384 wrap");
	a_div_wrap_256: assert property (@(posedge ref_clk) disable iff (sys_rst)
		osc_rise && ratio_256_sel && div_q == DIV_256 |=> biphase_en)
		else $error("no biphase pulse at 256 wrap");
	a_div_no_early: assert property (@(posedge ref_clk) disable iff (sys_rst)
		osc_rise && div_q < div_end |=> !biphase_en)
		else $error("biphase pulse before divider wrap");

	// handed words stand between pairs; the left one comes from the held left word
	a_pair_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!pair_valid |-> $stable(left_sample) && $stable(right_sample))
		else $error("samples changed without pair valid");
	a_left_to_out: assert property (@(posedge ref_clk) disable iff (sys_rst)
		pair_valid |-> left_sample == $past(lh_q))
		else $error("left sample not the held left word");
endmodule

//--- verification/sptx_audio_src.sv
// serial audio source model: bit clock, frame sync, data
// assumes: ref_clk free running, one frame per send_frame call
`timescale 1ns/1ns
module sptx_audio_src (
	input wire logic ref_clk,
	output logic bit_clk,
	output logic frame_sync,
	output logic ser_data
);
	initial begin
		bit_clk = 1'b0;
		frame_sync = 1'b0;
		ser_data = 1'b0;
	end
	// one bit slot: two cycles low, then high; sync and data change with the fall
	task automatic send_slot(input logic sync, input logic bit_val);
		@(posedge ref_clk);
		#2;
		bit_clk = 1'b0;
		frame_sync = sync;
		ser_data = bit_val;
		repeat (2) @(posedge ref_clk);
		#2;
		bit_clk = 1'b1;
		@(posedge ref_clk);
		#2;
	endtask
	// left then right word; i2s closes in its last slot, left-justified in an extra one
	task automatic send_frame(input logic lj, input logic [47:0] words);
		int k;
		// a sync left high would hide the opening transition
		if (frame_sync)
			send_slot(1'b0, 1'b0);
		for (k = 0; k < 48; k++) begin
			if (lj)
				send_slot(k < 24, words[47-k]);
			else
				send_slot(k >= 23 && k < 47, words[47-k]);
		end
		if (lj)
			send_slot(1'b1, 1'b0);
	endtask
endmodule

//--- verification/test_spdif_tx_serial_input.sv
// testbench for the serial audio input stage
// assumes: source model drives the serial side
`timescale 1ns/1ns
module test_spdif_tx_serial_input;
	import sptx_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	sptx_fmt_t fmt_sel = SPTX_FMT_I2S;
	logic ratio_256_sel = 1'b0;
	logic osc_clk = 1'b0;
	logic bit_clk, frame_sync, ser_data, pair_valid, biphase_en;
	logic [SAMPLE_W-1:0] left_sample, right_sample;
	int err_count = 0;
	int check_count = 0;
	always #25 ref_clk = ~ref_clk;
	// oversampling clock rises every second cycle
	always @(posedge ref_clk) #2 osc_clk = ~osc_clk;
	sptx_audio_src sptx_audio_src_inst (.ref_clk(ref_clk), .bit_clk(bit_clk),
		.frame_sync(frame_sync), .ser_data(ser_data));
	sptx_serial_in sptx_serial_in_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.fmt_sel(fmt_sel), .ratio_256_sel(ratio_256_sel), .bit_clk(bit_clk),
		.frame_sync(frame_sync), .ser_data(ser_data), .oversampling_clock_in(osc_clk),
		.left_sample(left_sample), .right_sample(right_sample),
		.pair_valid(pair_valid), .biphase_en(biphase_en));
	task automatic check(input logic [SAMPLE_W-1:0] seen, input logic [SAMPLE_W-1:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// one frame, then the handed pair is compared
	task automatic frame_case(input sptx_fmt_t fmt, input logic [47:0] words);
		int n;
		fmt_sel = fmt;
		sptx_audio_src_inst.send_frame(fmt == SPTX_FMT_LJ, words);
		for (n = 0; n < 6 && pair_valid !== 1'b1; n++) begin
			@(posedge ref_clk);
			#2;
		end
		if (pair_valid !== 1'b1) begin
			err_count++;
			final_report();
		end
		check(left_sample, words[47:24]);
		check(right_sample, words[23:0]);
	endtask
	// biphase pulses counted over 48 cycles
	task automatic ratio_case(input logic sel, input int ratio);
		int n;
		logic [SAMPLE_W-1:0] cnt;
		cnt = '0;
		ratio_256_sel = sel;
		repeat (12) @(posedge ref_clk);
		for (n = 0; n < 48; n++) begin
			@(posedge ref_clk);
			#2;
			cnt += biphase_en;
		end
		check(cnt, 24'(48 * BIPHASE_PER_FRAME / (2 * ratio)));
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		#2;
		sys_rst = 1'b0;
		frame_case(SPTX_FMT_I2S, 48'ha5c3e1_3c5a96);
		frame_case(SPTX_FMT_I2S, 48'h800001_7ffffe);
		frame_case(SPTX_FMT_LJ, 48'hc0ffee_123456);
		frame_case(SPTX_FMT_I2S, 48'h0f0f0f_f0f0f0);
		ratio_case(1'b0, RATIO_384);
		ratio_case(1'b1, RATIO_256);
		final_report();
	end
endmodule
